//--- src/ppmc_pkg.sv
/*
 * Constants and carrier types for the power-management capability block.
 * Assumes configuration cycles reach it as dword accesses with byte enables.
 */
package ppmc_pkg;

    localparam logic [7:0]  CAP_DWORD_ADDR   = 8'h44;
    localparam logic [7:0]  CAP_WORD_OFFSET  = 8'h46;
    localparam logic [7:0]  CTRL_WORD_OFFSET = 8'h48;

    localparam logic [15:0] CAP_RESET_ON     = 16'h4000;
    localparam logic [15:0] CTRL_RESET_ON    = 16'h8000;
    localparam logic [15:0] WORD_RESET_OFF   = 16'h0000;

    localparam int          WAKE_SUPPORT_MSB = 15;
    localparam int          WAKE_SUPPORT_LSB = 11;
    localparam logic [4:0]  WAKE_SUPPORT_VAL = 5'h08;
    localparam int          WAKE_FLAG_BIT    = 15;
    localparam int          WAKE_ENABLE_BIT  = 8;
    localparam int          STATE_MSB        = 1;
    localparam int          STATE_LSB        = 0;

    typedef enum logic [1:0] {
        PS_D0    = 2'b00,
        PS_D1    = 2'b01,
        PS_D2    = 2'b10,
        PS_D3HOT = 2'b11
    } ppmc_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  byteEn;
        logic [31:0] data;
    } ppmc_cfg_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] data;
    } ppmc_cfg_rsp_t;

endpackage

//--- src/ppmc_power_mgmt.sv
/*
 * Power-management capability words and wake signal control.
 * Assumes configuration requests arrive on sys_clk from bus logic, and that
 * the capabilities-enable level and the wake event come from same-clock logic.
 */
`timescale 1ns/1ps

// Functional notes
// - The wake support field reads 01000, only bit 14 set, wake from D3hot.
// - The wake signal is never asserted outside the D3hot state.
// - Capability bits 10 and 9 read zero, no intermediate states.
// - Capability bit 8 reads zero, no dynamic power data.
// - Capability bit 5 reads zero, no special driver initialization.
// - Capability bit 4 reads zero, no wake from D3cold.
// - Capability bit 3 reads zero, no bus clock needed for wake.
// - Capability version bits 2 to 0 read zero.
// - Capabilities word is 4000h only with capabilities enabled, else zero.
// - The wake flag is set whenever the wake signal is asserted.
// - Writing one clears the flag and drops wake unless a wake is raised in the same cycle; writing zero does nothing.
// - The wake enable bit is read/write, resets to zero, gates the wake.
// - Control bits 14 to 9 and bit 4 always read zero.
// - The power-state field is read/write, 00 D0 through 11 D3hot.
// - A write of 01 or 10 to the power-state field selects D0.
// - Control word resets to 8000h when enabled, else to zero.
module ppmc_power_mgmt
    import ppmc_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          clkEn,
    input  wire logic          capEnable,
    input  wire logic          wakeEvent,
    input  wire ppmc_cfg_req_t cfgReq,
    output ppmc_cfg_rsp_t      cfgRsp,
    output logic               wakeOut,
    output logic               wakeOe_n
);

    logic        wakeFlag_r;
    logic        wakeFlag_nxt;
    logic        wakeEn_r;
    logic        wakeEn_nxt;
    ppmc_state_t powerState_r;
    ppmc_state_t powerState_nxt;
    logic        wakeDrive_r;
    logic        wakeDrive_nxt;
    logic        rspAck_r;
    logic [31:0] rspData_r;

    // Address decode
    wire         hitCap    = cfgReq.addr == CAP_DWORD_ADDR;
    wire         hitCtrl   = cfgReq.addr == CTRL_WORD_OFFSET;
    wire         ctrlWr    = cfgReq.wr && hitCtrl && capEnable;
    wire         wrLowByte = ctrlWr && cfgReq.byteEn[0];
    wire         wrHiByte  = ctrlWr && cfgReq.byteEn[1];
    wire [15:0]  wrWord    = cfgReq.data[15:0];

    // Capability word, constant apart from the enable
    wire [15:0]  capWord   = capEnable ? CAP_RESET_ON
                                       : WORD_RESET_OFF;

    // Control word view, unused bits fixed at zero
    wire [15:0]  ctrlWord  = capEnable ? {wakeFlag_r, 6'h00, wakeEn_r,
                                          3'h0, 1'b0, 2'h0,
                                          powerState_r}
                                       : WORD_RESET_OFF;

    // Wake raised only from D3hot with the enable set
    wire         wakeCause = wakeEvent && wakeEn_nxt && capEnable
                           && powerState_nxt == PS_D3HOT;
    wire         flagClear = wrHiByte && wrWord[WAKE_FLAG_BIT];

    // Power-state write, intermediate states fold to D0
    wire [1:0]   stateWr   = wrWord[STATE_MSB:STATE_LSB];
    wire         stateMid  = stateWr == PS_D1 || stateWr == PS_D2;
    wire [1:0]   stateReq  = stateMid ? PS_D0 : stateWr;

    assign wakeFlag_nxt  = wakeCause ? 1'b1
                         : flagClear ? 1'b0 : wakeFlag_r;
    assign wakeEn_nxt    = wrHiByte ? wrWord[WAKE_ENABLE_BIT]
                                    : wakeEn_r;
    assign powerState_nxt = wrLowByte ? ppmc_state_t'(stateReq)
                                      : powerState_r;
    assign wakeDrive_nxt = wakeCause ? 1'b1
                         : (flagClear || !capEnable || !wakeEn_nxt
                            || powerState_nxt != PS_D3HOT)
                           ? 1'b0 : wakeDrive_r;

    wire [31:0]  rdMux = hitCap  ? {capWord, 16'h0000}
                       : hitCtrl ? {16'h0000, ctrlWord}
                       : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wakeFlag_r   <= capEnable;
            wakeEn_r     <= 1'b0;
            powerState_r <= PS_D0;
            wakeDrive_r  <= 1'b0;
        end else if (clkEn) begin
            wakeFlag_r   <= wakeFlag_nxt;
            wakeEn_r     <= wakeEn_nxt;
            powerState_r <= powerState_nxt;
            wakeDrive_r  <= wakeDrive_nxt;
        end
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rspAck_r  <= 1'b0;
            rspData_r <= 32'h0000_0000;
        end else if (clkEn) begin
            rspAck_r  <= cfgReq.rd || cfgReq.wr;
            rspData_r <= cfgReq.rd ? rdMux : rspData_r;
        end
    end

    assign cfgRsp.ack  = rspAck_r && clkEn;
    assign cfgRsp.data = rspData_r;

    // Open-drain wake pin, pulled low while asserted
    assign wakeOut  = 1'b0;
    assign wakeOe_n = !wakeDrive_r;

    // Checks
    logic        lastCapRd_r;
    logic        lastCtrlRd_r;
    logic        lastCapEn_r;
    logic        lastOtherRd_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lastCapRd_r   <= 1'b0;
            lastCtrlRd_r  <= 1'b0;
            lastCapEn_r   <= 1'b0;
            lastOtherRd_r <= 1'b0;
        end else if (clkEn) begin
            lastCapRd_r   <= cfgReq.rd && hitCap;
            lastCtrlRd_r  <= cfgReq.rd && hitCtrl;
            lastCapEn_r   <= capEnable;
            lastOtherRd_r <= cfgReq.rd && !hitCap && !hitCtrl;
        end
    end

    chk_wake_only_d3: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !wakeOe_n |-> powerState_r == PS_D3HOT)
        else $error("wake driven outside D3hot");

    chk_wake_needs_en: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !wakeOe_n |-> wakeEn_r && wakeFlag_r)
        else $error("wake driven without enable or flag");

    chk_wake_sets_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wakeCause |=> wakeFlag_r && !wakeOe_n)
        else $error("wake cause did not set flag and pin");

    chk_clear_drops_wake: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && flagClear && !wakeCause |=> !wakeFlag_r && wakeOe_n)
        else $error("write one did not clear flag and pin");

    chk_zero_keeps_flag: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrHiByte && !wrWord[WAKE_FLAG_BIT] && wakeFlag_r
        |=> wakeFlag_r)
        else $error("write zero changed flag");

    chk_mid_state_d0: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrLowByte && stateMid |=> powerState_r == PS_D0)
        else $error("intermediate state not folded to D0");

    chk_state_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrLowByte && stateWr == PS_D3HOT
        |=> powerState_r == PS_D3HOT)
        else $error("D3hot write not taken");

    chk_cap_read_val: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        lastCapRd_r && cfgRsp.ack
        |-> cfgRsp.data[31:16] == (lastCapEn_r ? 16'h4000 : 16'h0000))
        else $error("capabilities word read wrong");

    chk_ctrl_zero_bits: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        lastCtrlRd_r && cfgRsp.ack
        |-> cfgRsp.data[14:9] == 6'h00 && cfgRsp.data[7:2] == 6'h00
            && cfgRsp.data[31:16] == 16'h0000)
        else $error("control word fixed bits not zero");

    chk_reset_value: assert property (
        @(posedge sys_clk)
        !rst_n ##1 rst_n |-> ctrlWord ==
            ($past(capEnable) ? 16'h8000 : 16'h0000) && wakeOe_n)
        else $error("control word reset value wrong");

    chk_reset_state: assert property (
        @(posedge sys_clk)
        !rst_n ##1 rst_n
        |-> !wakeEn_r && powerState_r == PS_D0)
        else $error("enable or state reset value wrong");

    chk_ack_follows_req: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && (cfgReq.rd || cfgReq.wr)
        |=> cfgRsp.ack || !clkEn)
        else $error("request not acknowledged");

    chk_ack_one_cycle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && !cfgReq.rd && !cfgReq.wr
        |=> !cfgRsp.ack)
        else $error("acknowledge without request");

    chk_data_held: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && !cfgReq.rd
        |=> $stable(cfgRsp.data))
        else $error("read data changed without read");

    chk_freeze_state: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !clkEn
        |=> $stable(wakeFlag_r) && $stable(wakeEn_r)
            && $stable(powerState_r) && $stable(wakeOe_n))
        else $error("state moved while clock enable low");

    chk_cap_off_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && cfgReq.wr && !capEnable
        |=> $stable(wakeEn_r) && $stable(powerState_r) && $stable(wakeFlag_r))
        else $error("write taken while capabilities disabled");

    chk_cap_word_ro: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && cfgReq.wr && hitCap
        |=> $stable(wakeEn_r) && $stable(powerState_r))
        else $error("capabilities word write changed state");

    chk_enable_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrHiByte
        |=> wakeEn_r == $past(wrWord[WAKE_ENABLE_BIT]))
        else $error("wake enable write not taken");

    chk_enable_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && !wrHiByte
        |=> $stable(wakeEn_r))
        else $error("wake enable changed without write");

    chk_state_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && !wrLowByte
        |=> $stable(powerState_r))
        else $error("power state changed without write");

    chk_state_d0_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrLowByte && stateWr == PS_D0
        |=> powerState_r == PS_D0)
        else $error("D0 write not taken");

    chk_flag_needs_cause: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && !wakeCause && !wakeFlag_r
        |=> !wakeFlag_r)
        else $error("wake flag set without wake");

    chk_set_beats_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wakeCause && flagClear
        |=> wakeFlag_r && !wakeOe_n)
        else $error("clear beat a same-cycle wake");

    chk_pin_needs_cause: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(wakeOe_n)
        |-> $past(wakeCause && clkEn))
        else $error("wake pin driven without cause");

    chk_state_leave_drop: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrLowByte && stateReq != PS_D3HOT
        |=> wakeOe_n)
        else $error("wake kept after leaving D3hot");

    chk_enable_off_drop: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clkEn && wrHiByte && !wrWord[WAKE_ENABLE_BIT]
        |=> wakeOe_n)
        else $error("wake kept after enable cleared");

    chk_cap_read_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        lastCapRd_r && cfgRsp.ack
        |-> cfgRsp.data[15:0] == 16'h0000)
        else $error("capabilities dword low half not zero");

    chk_unmapped_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        lastOtherRd_r && cfgRsp.ack
        |-> cfgRsp.data == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule // ppmc_power_mgmt

//--- sim/ppmc_host_model.sv
/*
 * Host side of the wake line: pull-up resolving the open-drain pin.
 * Assumes the block drives wakeOut and an active low output enable.
 */
`timescale 1ns/1ps
module ppmc_host_model
    import ppmc_pkg::*;
(
    input  wire logic wakeOut,
    input  wire logic wakeOe_n,
    output logic      wakeLine_n
);
    // Released line floats up to the pull-up level
    assign wakeLine_n = wakeOe_n ? 1'b1 : wakeOut;
endmodule // ppmc_host_model

//--- sim/testbench.sv
/*
 * Self-checking bench for the power-management capability block.
 * Assumes the host model supplies the pulled-up wake line.
 */
`timescale 1ns/1ps
module testbench;
    import ppmc_pkg::*;
    logic          sys_clk, rst_n, clkEn, capEnable, wakeEvent;
    logic          wakeOut, wakeOe_n, wakeLine_n;
    ppmc_cfg_req_t req;
    ppmc_cfg_rsp_t rsp;
    int            nFail, compares;

    ppmc_power_mgmt DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
        .capEnable(capEnable), .wakeEvent(wakeEvent), .cfgReq(req),
        .cfgRsp(rsp), .wakeOut(wakeOut), .wakeOe_n(wakeOe_n));
    ppmc_host_model host (.wakeOut(wakeOut), .wakeOe_n(wakeOe_n),
        .wakeLine_n(wakeLine_n));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        $display("compares=%0d n_fail=%0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One config cycle, bounded wait for the acknowledge
    task automatic cyc(logic w, logic [7:0] a, logic [3:0] be,
                       logic [31:0] d);
        int i;
        req = '{rd: !w, wr: w, addr: a, byteEn: be, data: d};
        @(posedge sys_clk);
        #1;
        req.rd = 1'b0;
        req.wr = 1'b0;
        for (i = 0; i < 4 && rsp.ack !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (rsp.ack !== 1'b1) begin
            nFail++;
            wrap_up();
        end
        @(posedge sys_clk);
        #1;
        chk("ackPulse", 32'h0000_0000, {31'h0, rsp.ack});
    endtask

    task automatic rdChk(string nm, logic [7:0] a, logic [31:0] e);
        cyc(1'b0, a, 4'h0, 32'h0000_0000);
        chk(nm, e, rsp.data);
    endtask

    task automatic doReset(logic cap);
        capEnable = cap;
        rst_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
    endtask

    task automatic pulse;
        wakeEvent = 1'b1;
        @(posedge sys_clk);
        #1;
        wakeEvent = 1'b0;
    endtask

    task automatic tCapOff;
        doReset(1'b0);
        rdChk("capWord", 8'h44, 32'h0000_0000);
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_0103);
        rdChk("ctrlWord", 8'h48, 32'h0000_0000);
        capEnable = 1'b1;
        rdChk("ctrlRefused", 8'h48, 32'h0000_0000);
    endtask

    task automatic tCapOn;
        doReset(1'b1);
        rdChk("cap", 8'h44, 32'h4000_0000);
        rdChk("unmapped", 8'h40, 32'h0000_0000);
        rdChk("ctrlWord", 8'h48, 32'h0000_8000);
        cyc(1'b1, 8'h44, 4'hf, 32'hffff_ffff);
        rdChk("capWord", 8'h44, 32'h4000_0000);
    endtask

    task automatic tStates;
        logic [1:0]  s;
        logic [31:0] e;
        for (int k = 0; k < 4; k++) begin
            s = k[1:0];
            e = (s == 2'b11) ? 32'h0000_8003 : 32'h0000_8000;
            cyc(1'b1, 8'h48, 4'h1, {30'h0, s});
            rdChk("state", 8'h48, e);
        end
    endtask

    task automatic tWake;
        cyc(1'b1, 8'h48, 4'hf, 32'hffff_ffff);
        rdChk("ctrlWord", 8'h48, 32'h0000_0103);
        pulse();
        chk("wakeLine", 32'h0, {31'h0, wakeLine_n});
        rdChk("flagSet", 8'h48, 32'h0000_8103);
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_0103);
        rdChk("flagKept", 8'h48, 32'h0000_8103);
        chk("wakeHeld", 32'h0, {31'h0, wakeLine_n});
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_8103);
        rdChk("flagClr", 8'h48, 32'h0000_0103);
        chk("wakeDrop", 32'h1, {31'h0, wakeLine_n});
    endtask

    task automatic tGate;
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_0003);
        pulse();
        chk("wakeNoEn", 32'h1, {31'h0, wakeLine_n});
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_0100);
        pulse();
        chk("wakeInD0", 32'h1, {31'h0, wakeLine_n});
    endtask

    // Control write with a wake event on the same edge
    task automatic wrEv(logic [31:0] d);
        req = '{rd: 1'b0, wr: 1'b1, addr: 8'h48, byteEn: 4'h3, data: d};
        wakeEvent = 1'b1;
        @(posedge sys_clk);
        #1;
        req.wr = 1'b0;
        wakeEvent = 1'b0;
        chk("ackEv", 32'h1, {31'h0, rsp.ack});
        @(posedge sys_clk);
        #1;
    endtask

    task automatic tRace;
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_0103);
        wrEv(32'h0000_0103);
        chk("wakeSet", 32'h0, {31'h0, wakeLine_n});
        wrEv(32'h0000_8103);
        chk("setWins", 32'h0, {31'h0, wakeLine_n});
        rdChk("setWinsFlag", 8'h48, 32'h0000_8103);
        wrEv(32'h0000_8100);
        chk("leaveD3", 32'h1, {31'h0, wakeLine_n});
        rdChk("leaveD3Flag", 8'h48, 32'h0000_0100);
    endtask

    task automatic tFreeze;
        cyc(1'b1, 8'h48, 4'h3, 32'h0000_0103);
        clkEn = 1'b0;
        wakeEvent = 1'b1;
        req = '{rd: 1'b1, wr: 1'b0, addr: 8'h44, byteEn: 4'h0, data: 32'h0};
        @(posedge sys_clk);
        #1;
        chk("frozenPin", 32'h1, {31'h0, wakeLine_n});
        req.rd = 1'b0;
        wakeEvent = 1'b0;
        clkEn = 1'b1;
        chk("frozenAck", 32'h0, {31'h0, rsp.ack});
        chk("frozenData", 32'h0000_0100, rsp.data);
        @(posedge sys_clk);
        #1;
        rdChk("frozenFlag", 8'h48, 32'h0000_0103);
    endtask

    initial begin
        nFail = 0;
        compares = 0;
        clkEn = 1'b1;
        wakeEvent = 1'b0;
        capEnable = 1'b0;
        rst_n = 1'b0;
        req = '0;
        tCapOff();
        tCapOn();
        tStates();
        tWake();
        tGate();
        tRace();
        tFreeze();
        wrap_up();
    end
endmodule // testbench
